// ---- eeprom_prog_pkg.sv ----
package eeprom_prog_pkg;
    // timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int PROG_TIME_MS   = 10;
    localparam int PROG_CYCLES    = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TIMER_W        = 19;

    // frame layout, bit positions counted from the start bit
    localparam int START_BITS     = 1;
    localparam int OPC_BITS       = 4;
    localparam int POS_OPC        = 1;
    localparam int POS_ADDR       = 5;
    localparam int ADDR_BITS_WORD = 4;
    localparam int ADDR_BITS_BYTE = 5;
    localparam int DATA_BITS_WORD = 16;
    localparam int DATA_BITS_BYTE = 8;
    localparam int WR_PULSES_BYTE = 18;
    localparam int WR_PULSES_WORD = 25;
    localparam int FRAME_BITS     = 25;
    localparam int CNT_W          = 5;
    localparam int CNT_MAX        = 31;

    // array
    localparam int WORDS          = 16;
    localparam int WORD_W         = 16;
    localparam int WADDR_W        = 4;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;

    // op-codes
    localparam logic [1:0] OP2_WRITE   = 2'h1;
    localparam logic [1:0] OP2_ERASE   = 2'h3;
    localparam logic [3:0] OP_UNLOCK   = 4'h3;
    localparam logic [3:0] OP_LOCK     = 4'h0;
    localparam logic [3:0] OP_CLEAR    = 4'h2;
    localparam logic [3:0] OP_FILL     = 4'h1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01
    } prog_state_e;
endpackage

// ---- frame_if.sv ----
`timescale 1ns/1ps
interface frame_if import eeprom_prog_pkg::*;;
    logic                  tog;
    logic                  started;
    logic [CNT_W-1:0]      count;
    logic [FRAME_BITS-1:0] bits;

    modport rx   (output tog, output started, output count, output bits);
    modport core (input tog, input started, input count, input bits);
endinterface

// ---- sync2.sv ----
`timescale 1ns/1ps
module sync2 import eeprom_prog_pkg::*; #(
    parameter int width = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [width-1:0] d,
    output logic [width-1:0]      q
);
    logic [width-1:0] meta_ff;
    logic [width-1:0] q_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule

// ---- serial_frame_rx.sv ----
`timescale 1ns/1ps
module serial_frame_rx import eeprom_prog_pkg::*; #(
    parameter bit enhanced = 1'b1
) (
    input  wire logic sclk,
    input  wire logic cs,
    input  wire logic din,
    input  wire logic reset,
    frame_if.rx       frm
);
    logic                  open_ff;
    logic                  started_ff;
    logic                  tog_ff;
    logic [CNT_W-1:0]      cnt_ff;
    logic [FRAME_BITS-1:0] bits_ff;
    logic                  clr;
    logic                  take_start;

    // frame flags end with the frame itself, since sclk may stop after it
    assign clr        = reset | ~cs;
    // basic variant drops the first pulse; enhanced may take it as start
    assign take_start = !started_ff && (open_ff || enhanced) && din;

    always_ff @(posedge sclk or posedge clr) begin
        if (clr) begin
            open_ff    <= 1'b0;
            started_ff <= 1'b0;
        end else begin
            open_ff <= 1'b1;
            if (take_start) begin
                started_ff <= 1'b1;
            end
        end
    end

    // count and bits survive cs low so the core can read them afterwards
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            tog_ff  <= 1'b0;
            cnt_ff  <= '0;
            bits_ff <= '0;
        end else begin
            if (!open_ff) begin
                tog_ff <= ~tog_ff;
            end
            if (take_start) begin
                cnt_ff  <= CNT_W'(START_BITS);
                bits_ff <= FRAME_BITS'(1);
            end else if (started_ff) begin
                if (cnt_ff != CNT_W'(CNT_MAX)) begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                end
                if (cnt_ff < CNT_W'(FRAME_BITS)) begin
                    bits_ff[cnt_ff] <= din;
                end
            end else if (!open_ff) begin
                cnt_ff  <= '0;
                bits_ff <= '0;
            end
        end
    end

    chk_start_taken: assert property (@(posedge sclk) disable iff (clr)
        take_start |=> started_ff && cnt_ff == CNT_W'(START_BITS))
        else $error("start bit not recorded");

    assign frm.tog     = tog_ff;
    assign frm.started = started_ff;
    assign frm.count   = cnt_ff;
    assign frm.bits    = bits_ff;
endmodule

// ---- serial_eeprom_program_ctrl.sv ----
// Operation
// - write carries address then 8/16 data
// - input bits captured on clock rise
// - busy ignores input, drives output low
// - completion drives output high, accepts instructions
// - programming cycle timed internally
// - write erases location automatically first
// - bulk clear sets whole array ones
// - fill programs every location, no erase
// - status shown while select high
// - ready held until start or deselect
// - basic variant ignores first clock pulse
// - enhanced counts pulses from start bit
// - byte write needs exactly 18 pulses when enhanced, at least 18 in basic
// - word write needs exactly 25 pulses when enhanced, at least 25 in basic
// - full count checked only on programming instructions; others need start bit plus op-code
// - array starts as all ones
// - four-bit op-codes, 4/5 address bits
// - programming needs unlock, powers up locked
// - first one after select is start
// - organization pin high selects words
`timescale 1ns/1ps
module serial_eeprom_program_ctrl import eeprom_prog_pkg::*; #(
    parameter bit          enhanced    = 1'b1,
    parameter int unsigned prog_cycles = PROG_CYCLES
) (
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               sclk,
    input  wire logic               cs,
    input  wire logic               din,
    input  wire logic               org,
    input  wire logic [WADDR_W-1:0] mem_addr,
    output logic                    dout,
    output logic                    dout_oe,
    output logic                    busy,
    output logic                    write_enabled,
    output logic [WORD_W-1:0]       mem_rdata
);
    frame_if frm();

    serial_frame_rx #(
        .enhanced (enhanced)
    ) u_rx (
        .sclk  (sclk),
        .cs    (cs),
        .din   (din),
        .reset (reset),
        .frm   (frm)
    );

    logic [3:0] sync_d;
    logic [3:0] sync_q;
    logic       cs_s;
    logic       org_s;
    logic       started_s;
    logic       tog_s;

    assign sync_d = {cs, org, frm.started, frm.tog};

    sync2 #(
        .width (4)
    ) u_sync (
        .clk   (core_clk),
        .reset (reset),
        .d     (sync_d),
        .q     (sync_q)
    );

    assign cs_s      = sync_q[3];
    assign org_s     = sync_q[2];
    assign started_s = sync_q[1];
    assign tog_s     = sync_q[0];

    prog_state_e          state_ff;
    logic                 busy_ff;
    logic                 cs_d_ff;
    logic                 taken_tog_ff;
    logic                 unlocked_ff;
    logic                 ready_ff;
    logic                 dout_ff;
    logic                 dout_oe_ff;
    logic [TIMER_W-1:0]   timer_ff;
    logic [WORD_W-1:0]    mem_ff [WORDS];
    logic [WORD_W-1:0]    rdata_ff;

    // pick n bits from position pos onward, first bit ends up most significant
    function automatic logic [15:0] field(input logic [FRAME_BITS-1:0] b, input int pos, input int n);
        logic [15:0] f;
        f = '0;
        for (int i = 0; i < 16; i++) begin
            if (i < n && pos + i < FRAME_BITS) begin
                f = {f[14:0], b[pos+i]};
            end
        end
        return f;
    endfunction

    logic                 cs_fall;
    logic                 take;
    logic [3:0]           opc;
    logic [15:0]          addr_f;
    logic [15:0]          data_f;
    logic                 is_write;
    logic                 is_erase;
    logic                 is_clear;
    logic                 is_fill;
    logic                 prog_op;
    logic                 len_ok;
    logic                 start_prog;
    logic                 prog_done;
    logic [WADDR_W-1:0]   word_idx;
    logic                 hi_lane;
    logic [WORD_W-1:0]    fill_word;
    int                   aw;
    int                   need;

    assign cs_fall = cs_d_ff && !cs_s;
    // count and bits are still while cs is low, so no sync is needed on them
    assign take    = cs_fall && (tog_s != taken_tog_ff);

    always_comb begin
        aw       = org_s ? ADDR_BITS_WORD : ADDR_BITS_BYTE;
        opc      = 4'(field(frm.bits, POS_OPC, OPC_BITS));
        addr_f   = field(frm.bits, POS_ADDR, aw);
        data_f   = field(frm.bits, POS_ADDR + aw, org_s ? DATA_BITS_WORD : DATA_BITS_BYTE);
        is_write = opc[3:2] == OP2_WRITE;
        is_erase = opc[3:2] == OP2_ERASE;
        is_clear = opc == OP_CLEAR;
        is_fill  = opc == OP_FILL;
        prog_op  = is_write || is_erase || is_clear || is_fill;
        if (is_write || is_fill) begin
            need = org_s ? WR_PULSES_WORD : WR_PULSES_BYTE;
        end else begin
            need = START_BITS + OPC_BITS + aw;
        end
        // the full count only guards programming (exact when enhanced); others just need the op-code
        if (enhanced && prog_op) begin
            len_ok = frm.count == CNT_W'(need);
        end else if (prog_op) begin
            len_ok = frm.count >= CNT_W'(need);
        end else begin
            len_ok = frm.count >= CNT_W'(START_BITS + OPC_BITS);
        end
        word_idx  = org_s ? addr_f[3:0] : addr_f[4:1];
        hi_lane   = !org_s && addr_f[0];
        fill_word = org_s ? data_f : {data_f[7:0], data_f[7:0]};
    end

    assign start_prog = take && state_ff == ST_IDLE && unlocked_ff && prog_op && len_ok;
    assign prog_done  = state_ff == ST_PROG && timer_ff == '0;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cs_d_ff      <= 1'b0;
            taken_tog_ff <= 1'b0;
        end else begin
            cs_d_ff <= cs_s;
            if (take) begin
                taken_tog_ff <= tog_s;
            end
        end
    end

    // frames that end while busy are dropped, the lock state included
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            unlocked_ff <= 1'b0;
        end else if (take && state_ff == ST_IDLE && len_ok) begin
            if (opc == OP_UNLOCK) begin
                unlocked_ff <= 1'b1;
            end else if (opc == OP_LOCK) begin
                unlocked_ff <= 1'b0;
            end
        end
    end

    // self-timed: only core_clk advances the cycle, sclk is irrelevant here
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'b0;
            timer_ff <= '0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (start_prog) begin
                        state_ff <= ST_PROG;
                        busy_ff  <= 1'b1;
                        timer_ff <= TIMER_W'(prog_cycles - 1);
                    end
                end
                ST_PROG: begin
                    if (prog_done) begin
                        state_ff <= ST_IDLE;
                        busy_ff  <= 1'b0;
                    end else begin
                        timer_ff <= timer_ff - TIMER_W'(1);
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    busy_ff  <= 1'b0;
                end
            endcase
        end
    end

    // array contents change at cycle start; status still waits the full time
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_ff[i] <= ERASED_WORD;
            end
        end else if (start_prog) begin
            if (is_write && org_s) begin
                mem_ff[word_idx] <= data_f;
            end else if (is_write && hi_lane) begin
                mem_ff[word_idx][15:8] <= data_f[7:0];
            end else if (is_write) begin
                mem_ff[word_idx][7:0] <= data_f[7:0];
            end else if (is_erase && org_s) begin
                mem_ff[word_idx] <= ERASED_WORD;
            end else if (is_erase && hi_lane) begin
                mem_ff[word_idx][15:8] <= ERASED_BYTE;
            end else if (is_erase) begin
                mem_ff[word_idx][7:0] <= ERASED_BYTE;
            end else begin
                for (int i = 0; i < WORDS; i++) begin
                    if (is_clear) begin
                        mem_ff[i] <= ERASED_WORD;
                    end else begin
                        // programming only clears bits, so fill ands into the old value
                        mem_ff[i] <= mem_ff[i] & fill_word;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= ERASED_WORD;
        end else begin
            rdata_ff <= mem_ff[mem_addr];
        end
    end

    // completion sets ready and wins over a clear in the same cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ready_ff <= 1'b0;
        end else if (prog_done) begin
            ready_ff <= 1'b1;
        end else if (cs_fall || (started_s && !busy_ff)) begin
            ready_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dout_ff    <= 1'b0;
            dout_oe_ff <= 1'b0;
        end else begin
            dout_ff    <= !busy_ff;
            dout_oe_ff <= cs_s && (busy_ff || ready_ff);
        end
    end

    assign dout          = dout_ff;
    assign dout_oe       = dout_oe_ff;
    assign busy          = busy_ff;
    assign write_enabled = unlocked_ff;
    assign mem_rdata     = rdata_ff;

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence seq_cycle_start;
        $rose(busy_ff);
    endsequence

    sequence seq_clear_go;
        take && state_ff == ST_IDLE && unlocked_ff && is_clear && len_ok;
    endsequence

    sequence seq_word_write_go;
        take && state_ff == ST_IDLE && unlocked_ff && is_write && org_s && len_ok;
    endsequence

    chk_busy_drives_low: assert property ((busy_ff && cs_s) |=> (dout_oe_ff && !dout_ff))
        else $error("busy not shown as low");

    chk_ready_drives_high: assert property ((dout_oe_ff && !$past(busy_ff)) |-> dout_ff)
        else $error("ready not shown as high");

    chk_done_sets_ready: assert property ($fell(busy_ff) |-> ready_ff)
        else $error("ready missing after cycle");

    chk_cycle_self_timed: assert property (seq_cycle_start |-> busy_ff[*8])
        else $error("programming cycle ended early");

    chk_clear_all_ones: assert property (seq_clear_go |=>
        mem_ff[0] == ERASED_WORD && mem_ff[WORDS-1] == ERASED_WORD)
        else $error("bulk clear left zeros");

    chk_word_write_data: assert property (seq_word_write_go |=>
        mem_ff[$past(word_idx)] == $past(data_f))
        else $error("word write wrong contents");

    chk_fill_no_erase: assert property ((start_prog && is_fill) |=>
        mem_ff[0] == ($past(mem_ff[0]) & $past(fill_word)))
        else $error("fill did not and into old data");

    chk_count_gate: assert property ((take && state_ff == ST_IDLE && prog_op && !len_ok)
        |=> !busy_ff)
        else $error("bad pulse count started programming");

    chk_lock_gate: assert property (seq_cycle_start |-> $past(unlocked_ff))
        else $error("programming while locked");

    chk_ignore_busy: assert property ((take && busy_ff) |=> $stable(unlocked_ff))
        else $error("frame accepted while busy");

    chk_ready_held: assert property ((ready_ff && !prog_done && !cs_fall && !started_s) |=> ready_ff)
        else $error("ready dropped early");

    chk_oe_needs_cs: assert property (!cs_s |=> !dout_oe_ff)
        else $error("output driven with select low");
endmodule

// ---- host_master.sv ----
`timescale 1ns/1ps
module host_master (
    output logic sclk,
    output logic cs,
    output logic din
);
    // link clock stands still low outside frames; status is read on a wire of its own,
    // so the last address bit never fights the first status bit
    initial begin
        sclk = 1'b0;
        cs   = 1'b0;
        din  = 1'b1;
    end

    // msb of the n lowest bits goes out first; slow stretches the low phase
    task automatic frame(input logic [31:0] bits, input int n, input bit slow);
        cs = 1'b1;
        #(40.3);
        for (int i = n - 1; i >= 0; i--) begin
            din = bits[i];
            #(31.25) sclk = 1'b1;
            #(62.5) sclk = 1'b0;
            #(slow ? 400.0 : 31.25);
        end
        cs  = 1'b0;
        din = ~din;                             // released line shows no stale value
        #(300.0);
    endtask

    task automatic select(input logic v);
        cs = v;
    endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    import eeprom_prog_pkg::*;
    localparam int PCYC = 200;
    typedef struct {logic is_word; logic [15:0] val;} note_s;
    logic                 core_clk = 1'b0;
    logic                 reset    = 1'b1;
    logic                 org      = 1'b1;
    logic [WADDR_W-1:0]   mem_addr = 4'h0;
    logic                 sclk, cs, din, dout, dout_oe, busy, write_enabled;
    logic [WORD_W-1:0]    mem_rdata;
    logic [15:0]          d, d2, f1, f2;
    logic [7:0]           b;
    logic [31:0]          rng = 32'h0000005A;
    note_s                note_q[$];
    event                 note_ev;
    int                   n_errors = 0;
    int                   n_tests  = 0;

    always #12.5 core_clk = ~core_clk;

    serial_eeprom_program_ctrl #(.enhanced(1'b1), .prog_cycles(PCYC)) serial_eeprom_program_ctrl_inst (
        .core_clk(core_clk), .reset(reset), .sclk(sclk), .cs(cs), .din(din), .org(org),
        .mem_addr(mem_addr), .dout(dout), .dout_oe(dout_oe), .busy(busy),
        .write_enabled(write_enabled), .mem_rdata(mem_rdata));
    host_master host_master_inst (.sclk(sclk), .cs(cs), .din(din));

    function automatic logic [15:0] rnd16;
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[15:0];
    endfunction

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_stat(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t status got %b expected %b", $time, got, exp);
        end
    endtask

    // status nibble: busy, output enable, driven level, unlocked
    initial forever begin
        @(note_ev);
        repeat (2) @(posedge core_clk);
        #1;
        if (note_q[0].is_word) cmp_word(mem_rdata, note_q[0].val);
        else cmp_stat({busy, dout_oe, dout_oe & dout, write_enabled}, note_q[0].val[3:0]);
        void'(note_q.pop_front());
    end

    task automatic exp_word(input logic [3:0] a, input logic [15:0] v);
        @(negedge core_clk);
        mem_addr = a;
        note_q.push_back('{1'b1, v});
        ->note_ev;
        repeat (4) @(negedge core_clk);
    endtask

    task automatic exp_stat(input logic [3:0] v);
        @(negedge core_clk);
        note_q.push_back('{1'b0, {12'h000, v}});
        ->note_ev;
        repeat (4) @(negedge core_clk);
    endtask

    task automatic exp_all(input logic [15:0] v);
        for (int i = 0; i < WORDS; i++) exp_word(i[3:0], v);
    endtask

    task automatic wait_idle;
        int k = 0;
        while (busy !== 1'b0 && k < 4 * PCYC) begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 4 * PCYC) begin
            n_errors++;
            $display("[FAIL] %0t busy never cleared", $time);
        end
    endtask

    task automatic final_report;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #2000000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        d  = rnd16();
        d2 = rnd16();
        f1 = rnd16();
        f2 = rnd16();
        b  = 8'(rnd16() >> 8);
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        exp_stat(4'h0);
        exp_word(4'h2, ERASED_WORD);
        host_master_inst.frame({7'h00, 1'b1, 4'h4, 4'h2, d}, 25, 0);
        exp_word(4'h2, ERASED_WORD);
        host_master_inst.frame({22'h0, 1'b0, 1'b1, 4'h3, 4'h0}, 10, 0);
        exp_stat(4'h1);
        host_master_inst.frame({7'h00, 1'b1, 4'h4, 4'h2, d}, 25, 0);
        exp_stat(4'h9);
        host_master_inst.select(1'b1);
        exp_stat(4'hD);
        host_master_inst.select(1'b0);
        repeat (12) @(negedge core_clk);
        host_master_inst.frame({23'h0, 1'b1, 4'h0, 4'h0}, 9, 0);
        host_master_inst.select(1'b1);
        wait_idle();
        exp_stat(4'h7);
        exp_stat(4'h7);
        host_master_inst.select(1'b0);
        exp_stat(4'h1);
        exp_word(4'h2, d);
        host_master_inst.frame({7'h00, 1'b1, 4'h4, 4'h2, d2}, 25, 0);
        wait_idle();
        exp_word(4'h2, d2);
        host_master_inst.frame({7'h00, 1'b1, 4'h4, 4'h5, d} >> 1, 24, 0);
        exp_stat(4'h1);
        host_master_inst.frame({7'h00, 1'b1, 4'h4, 4'h5, d} << 1, 26, 0);
        exp_stat(4'h1);
        exp_word(4'h5, ERASED_WORD);
        @(negedge core_clk);
        org = 1'b0;
        repeat (6) @(negedge core_clk);
        host_master_inst.frame({14'h0, 1'b1, 4'h4, 5'h07, b}, 18, 0);
        wait_idle();
        exp_word(4'h3, {b, ERASED_BYTE});
        host_master_inst.frame({14'h0, 1'b1, 4'h4, 5'h06, b} >> 1, 17, 0);
        exp_stat(4'h1);
        host_master_inst.frame({21'h0, 1'b1, 4'hC, 5'h07, 1'b0}, 11, 0);
        exp_word(4'h3, {b, ERASED_BYTE});
        host_master_inst.frame({22'h0, 1'b1, 4'hC, 5'h07}, 10, 0);
        wait_idle();
        exp_word(4'h3, ERASED_WORD);
        @(negedge core_clk);
        org = 1'b1;
        repeat (6) @(negedge core_clk);
        host_master_inst.frame({23'h0, 1'b1, 4'h2, 4'hA}, 9, 0);
        wait_idle();
        exp_all(ERASED_WORD);
        host_master_inst.frame({7'h00, 1'b1, 4'h1, 4'h0, f1}, 25, 1);
        wait_idle();
        exp_all(f1);
        host_master_inst.frame({7'h00, 1'b1, 4'h1, 4'h0, f2}, 25, 0);
        wait_idle();
        exp_all(f1 & f2);
        host_master_inst.frame({23'h0, 1'b1, 4'h0, 4'h0}, 9, 0);
        exp_stat(4'h0);
        host_master_inst.frame({7'h00, 1'b1, 4'h4, 4'h0, d}, 25, 0);
        exp_word(4'h0, f1 & f2);
        repeat (8) @(negedge core_clk);
        final_report();
    end
endmodule
